// ==== shared/iefr_pkg.sv ====
// register map, field positions and reset values of the request flag block
package iefr_pkg;
    localparam int unsigned REG_W = 8;
    localparam int unsigned EXT_N = 5;
    localparam int unsigned SYNC_W = 5;
    localparam int unsigned EDGE_W = 6;
    localparam int unsigned PF_W = 7;
    // register offsets
    localparam logic [7:0] ADDR_ENABLE_ONE = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_TWO = 8'h01;
    localparam logic [7:0] ADDR_EDGE_SEL = 8'h02;
    localparam logic [7:0] ADDR_FLAGS_ONE = 8'h03;
    localparam logic [7:0] ADDR_FLAGS_TWO = 8'h04;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h05;
    // field positions, first request and enable registers
    localparam int unsigned TA_BIT = 7;
    localparam int unsigned DS_BIT = 6;
    localparam int unsigned RSV_ONE_BIT = 5;
    // field positions, second request and enable registers
    localparam int unsigned DT_BIT = 7;
    localparam int unsigned AD_BIT = 6;
    localparam int unsigned RSV_TWO_BIT = 5;
    localparam int unsigned TG_BIT = 4;
    localparam int unsigned TFH_BIT = 3;
    localparam int unsigned TFL_BIT = 2;
    localparam int unsigned TC_BIT = 1;
    localparam int unsigned RSV_ZERO_BIT = 0;
    // pin function register fields
    localparam int unsigned PF_TG_PIN_BIT = 5;
    localparam int unsigned PF_TG_EDGE_BIT = 6;
    // reset values
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [4:0] EDGE_RESET = 5'h00;
    localparam logic [6:0] PIN_FUNC_RESET = 7'h00;
    // read and write masks
    localparam logic [7:0] FLAGS_ONE_FIXED = 8'h20;
    localparam logic [7:0] FLAGS_ONE_CLR = 8'hDF;
    localparam logic [7:0] FLAGS_TWO_CLR = 8'hDE;
    localparam logic [7:0] ENABLE_TWO_MASK = 8'hFE;
    localparam logic [7:0] EDGE_FIXED = 8'hE0;
    // counter wrap values
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
endpackage

// ==== src/iefr_pin_sync.sv ====
// two-stage synchroniser for asynchronous interrupt pins
`timescale 1ns/1ps
module iefr_pin_sync (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [iefr_pkg::SYNC_W-1:0] pin_in, // raw pins
    output logic [iefr_pkg::SYNC_W-1:0] pin_sync // synchronised pins
);
    import iefr_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } iefr_sync_t;

    iefr_sync_t s_r;
    iefr_sync_t s_nxt;

    // first stage is read only by the second
    always_comb begin
        s_nxt.stage1 = pin_in;
        s_nxt.stage2 = s_r.stage1;
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign pin_sync = s_r.stage2;
endmodule

// ==== src/iefr_edge_det.sv ====
// per-line selectable edge detector with pin function gating
`timescale 1ns/1ps
module iefr_edge_det (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [iefr_pkg::EDGE_W-1:0] sig, // synchronous lines
    input wire logic [iefr_pkg::EDGE_W-1:0] rise_sel, // 1 rising, 0 falling
    input wire logic [iefr_pkg::EDGE_W-1:0] func_en, // line is an irq input
    output logic [iefr_pkg::EDGE_W-1:0] pulse // one-cycle edge pulses
);
    import iefr_pkg::*;

    typedef struct packed {
        logic [EDGE_W-1:0] prev;
        logic primed;
    } iefr_edge_t;

    iefr_edge_t s_r;
    iefr_edge_t s_nxt;

    // remember last level; no edge before the first sample
    always_comb begin
        s_nxt.prev = sig;
        s_nxt.primed = 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // pick rising or falling per line
    for (genvar i = 0; i < EDGE_W; i++) begin : g_line
        assign pulse[i] = ce & s_r.primed & func_en[i] &
            (rise_sel[i] ? (sig[i] & ~s_r.prev[i])
                         : (~sig[i] & s_r.prev[i]));
    end
endmodule

// ==== src/iefr_top.sv ====
// interrupt enable and request flag registers with source event logic
`timescale 1ns/1ps
module iefr_top (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic ce, // clock enable, freezes state
    input wire logic [7:0] reg_addr, // register address
    input wire logic [iefr_pkg::REG_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [iefr_pkg::REG_W-1:0] reg_rdata, // read data, next cycle
    input wire logic [4:1] ext_edge_pin, // async edge irq pins
    input wire logic decoder_ready, // internal edge source 0
    input wire logic [7:0] timer_a_count, // timer A counter value
    input wire logic decoder_serial_done, // serial transfer end pulse
    input wire logic sleep_exec, // sleep instruction pulse
    input wire logic direct_transfer_on, // direct transfer control
    input wire logic converter_start_flag, // converter busy flag
    input wire logic timer_g_input_pin, // async timer G capture pin
    input wire logic timer_g_overflow, // timer G counter overflow pulse
    input wire logic overflow_irq_enable, // timer G overflow irq enable
    input wire logic [7:0] timer_f_high_counter, // timer F high counter
    input wire logic [7:0] timer_f_high_compare, // timer F high compare
    input wire logic [7:0] timer_f_low_counter, // timer F low counter
    input wire logic [7:0] timer_f_low_compare, // timer F low compare
    input wire logic timer_f_16bit_mode, // timer F cascaded mode
    input wire logic [7:0] timer_c_count, // timer C counter value
    output logic [iefr_pkg::REG_W-1:0] req_one, // requests, register one
    output logic [iefr_pkg::REG_W-1:0] req_two // requests, register two
);
    import iefr_pkg::*;

    typedef struct packed {
        logic [7:0] en_one;
        logic [7:0] en_two;
        logic [4:0] edge_sel;
        logic [6:0] pin_func;
        logic [7:0] flags_one;
        logic [7:0] flags_two;
        logic [7:0] rdata;
        logic [7:0] ta_prev;
        logic [7:0] tc_prev;
        logic start_prev;
        logic fh_match_prev;
        logic fl_match_prev;
    } iefr_state_t;

    localparam iefr_state_t STATE_RESET = '{
        en_one: ENABLE_RESET,
        en_two: ENABLE_RESET,
        edge_sel: EDGE_RESET,
        pin_func: PIN_FUNC_RESET,
        flags_one: FLAGS_RESET,
        flags_two: FLAGS_RESET,
        rdata: 8'h00,
        ta_prev: COUNT_ZERO,
        tc_prev: COUNT_ZERO,
        start_prev: 1'b0,
        fh_match_prev: 1'b0,
        fl_match_prev: 1'b0
    };

    iefr_state_t s_r;
    iefr_state_t s_nxt;

    logic [SYNC_W-1:0] pin_sync;
    logic [EDGE_W-1:0] edge_pulse;
    logic [EDGE_W-1:0] edge_rise;
    logic [EDGE_W-1:0] edge_func;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic fh_match;
    logic fl_match;
    logic wr_flags_one;
    logic wr_flags_two;

    // pins cross into the clock domain before any edge logic
    iefr_pin_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in({timer_g_input_pin, ext_edge_pin}),
        .pin_sync(pin_sync)
    );

    // lines 5..1 are pins (5 is the timer G pin), line 0 is the internal decoder signal
    assign edge_rise = {s_r.pin_func[PF_TG_EDGE_BIT], s_r.edge_sel};
    assign edge_func = {s_r.pin_func[PF_TG_PIN_BIT], s_r.pin_func[4:0]};

    iefr_edge_det u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .sig({pin_sync, decoder_ready}),
        .rise_sel(edge_rise),
        .func_en(edge_func),
        .pulse(edge_pulse)
    );

    // timer F compare matches
    always_comb begin
        if (timer_f_16bit_mode) begin
            fh_match = {timer_f_high_counter, timer_f_low_counter} ==
                {timer_f_high_compare, timer_f_low_compare};
            fl_match = 1'b0;
        end else begin
            fh_match = timer_f_high_counter == timer_f_high_compare;
            fl_match = timer_f_low_counter == timer_f_low_compare;
        end
    end

    // set conditions of the first request register
    always_comb begin
        set_one = 8'h00;
        set_one[TA_BIT] = ce & (s_r.ta_prev == COUNT_MAX) &
            (timer_a_count == COUNT_ZERO);
        set_one[DS_BIT] = ce & decoder_serial_done;
        set_one[4:0] = edge_pulse[4:0];
    end

    // set conditions of the second request register
    always_comb begin
        set_two = 8'h00;
        set_two[DT_BIT] = ce & sleep_exec & direct_transfer_on;
        set_two[AD_BIT] = ce & s_r.start_prev &
            ~converter_start_flag;
        set_two[TG_BIT] = edge_pulse[5] |
            (ce & timer_g_overflow & overflow_irq_enable);
        set_two[TFH_BIT] = ce & fh_match & ~s_r.fh_match_prev;
        set_two[TFL_BIT] = ce & fl_match & ~s_r.fl_match_prev;
        set_two[TC_BIT] = ce & (((s_r.tc_prev == COUNT_MAX) &
            (timer_c_count == COUNT_ZERO)) |
            ((s_r.tc_prev == COUNT_ZERO) &
            (timer_c_count == COUNT_MAX)));
    end

    assign wr_flags_one = reg_wr & (reg_addr == ADDR_FLAGS_ONE);
    assign wr_flags_two = reg_wr & (reg_addr == ADDR_FLAGS_TWO);

    // next state: register writes, flag update, reads, history
    always_comb begin
        s_nxt = s_r;
        s_nxt.ta_prev = timer_a_count;
        s_nxt.tc_prev = timer_c_count;
        s_nxt.start_prev = converter_start_flag;
        s_nxt.fh_match_prev = fh_match;
        s_nxt.fl_match_prev = fl_match;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_ENABLE_ONE: begin
                    s_nxt.en_one = reg_wdata;
                end
                ADDR_ENABLE_TWO: begin
                    s_nxt.en_two = reg_wdata & ENABLE_TWO_MASK;
                end
                ADDR_EDGE_SEL: begin
                    s_nxt.edge_sel = reg_wdata[4:0];
                end
                ADDR_PIN_FUNC: begin
                    s_nxt.pin_func = reg_wdata[6:0];
                end
                default: begin
                end
            endcase
        end
        // flags: write of 0 clears, 1 keeps; set wins over clear
        if (wr_flags_one) begin
            s_nxt.flags_one = s_r.flags_one &
                (reg_wdata | ~FLAGS_ONE_CLR);
        end
        s_nxt.flags_one = (s_nxt.flags_one | set_one) &
            FLAGS_ONE_CLR;
        if (wr_flags_two) begin
            s_nxt.flags_two = s_r.flags_two &
                (reg_wdata | ~FLAGS_TWO_CLR);
            s_nxt.flags_two[RSV_TWO_BIT] = reg_wdata[RSV_TWO_BIT];
        end
        s_nxt.flags_two = s_nxt.flags_two | set_two;
        s_nxt.flags_two[RSV_ZERO_BIT] = 1'b0;
        // read data stands only in the cycle after the strobe
        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_ENABLE_ONE: s_nxt.rdata = s_r.en_one;
                ADDR_ENABLE_TWO: s_nxt.rdata = s_r.en_two;
                ADDR_EDGE_SEL: s_nxt.rdata = {3'h0, s_r.edge_sel} |
                    EDGE_FIXED;
                ADDR_FLAGS_ONE: s_nxt.rdata = s_r.flags_one |
                    FLAGS_ONE_FIXED;
                ADDR_FLAGS_TWO: s_nxt.rdata = s_r.flags_two;
                ADDR_PIN_FUNC: s_nxt.rdata = {1'b0, s_r.pin_func};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // state register; acceptance by the controller has no path here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= STATE_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;

    // requests: flag and enable both set
    assign req_one = s_r.flags_one & s_r.en_one;
    assign req_two[DT_BIT] = s_r.flags_two[DT_BIT] & s_r.en_two[DT_BIT];
    assign req_two[AD_BIT] = s_r.flags_two[AD_BIT] & s_r.en_two[AD_BIT];
    assign req_two[RSV_TWO_BIT] = 1'b0;
    assign req_two[TG_BIT] = s_r.flags_two[TG_BIT] &
        s_r.en_two[TG_BIT];
    assign req_two[TFH_BIT] = s_r.flags_two[TFH_BIT] &
        s_r.en_two[TFH_BIT];
    assign req_two[TFL_BIT] = s_r.flags_two[TFL_BIT] &
        s_r.en_two[TFL_BIT];
    assign req_two[TC_BIT] = s_r.flags_two[TC_BIT] &
        s_r.en_two[TC_BIT];
    assign req_two[RSV_ZERO_BIT] = 1'b0;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_tg_gate_off: assert property (
        !s_r.en_two[TG_BIT] |-> !req_two[TG_BIT])
        else $error("timer G request passed while disabled");

    chk_fh_gate_pass: assert property (
        s_r.en_two[TFH_BIT] && s_r.flags_two[TFH_BIT] |-> req_two[TFH_BIT])
        else $error("timer FH request blocked while enabled");

    chk_fl_gate_off: assert property (
        !s_r.en_two[TFL_BIT] |-> !req_two[TFL_BIT])
        else $error("timer FL request passed while disabled");

    chk_tc_gate_off: assert property (
        !s_r.en_two[TC_BIT] |-> !req_two[TC_BIT])
        else $error("timer C request passed while disabled");

    chk_enable_bit_zero: assert property (
        ce && reg_rd && reg_addr == ADDR_ENABLE_TWO |=> !reg_rdata[0])
        else $error("enable two bit 0 read as one");

    chk_flag_stays_set: assert property (
        ce && s_r.flags_two[TG_BIT] && !wr_flags_two
        |=> s_r.flags_two[TG_BIT])
        else $error("timer G flag cleared without a write");

    chk_write_cannot_set: assert property (
        ce && wr_flags_one && reg_wdata[DS_BIT] &&
        !s_r.flags_one[DS_BIT] && !set_one[DS_BIT]
        |=> !s_r.flags_one[DS_BIT])
        else $error("write of one set the serial flag");

    chk_write_zero_clears: assert property (
        ce && wr_flags_one && !reg_wdata[TA_BIT] && !set_one[TA_BIT]
        |=> !s_r.flags_one[TA_BIT])
        else $error("write of zero failed to clear timer A flag");

    chk_reserved_one: assert property (
        ce && reg_rd && reg_addr == ADDR_FLAGS_ONE |=> reg_rdata[5])
        else $error("request one bit 5 read as zero");

    chk_ta_wrap_sets: assert property (
        ce && $past(ce) && $past(timer_a_count) == COUNT_MAX &&
        timer_a_count == COUNT_ZERO |=> s_r.flags_one[TA_BIT])
        else $error("timer A wrap did not set its flag");

    chk_ad_done_sets: assert property (
        ce && s_r.start_prev && !converter_start_flag
        |=> s_r.flags_two[AD_BIT])
        else $error("conversion end did not set its flag");

    chk_reserved_rw: assert property (
        ce && wr_flags_two |=> s_r.flags_two[RSV_TWO_BIT] ==
        $past(reg_wdata[RSV_TWO_BIT]))
        else $error("request two bit 5 did not store write");

    chk_set_beats_clear: assert property (
        ce && wr_flags_one && !reg_wdata[DS_BIT] && set_one[DS_BIT]
        |=> s_r.flags_one[DS_BIT])
        else $error("serial flag lost to a clearing write");

    chk_rdata_one_cycle: assert property (
        ce && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data held beyond its cycle");

    chk_serial_sets: assert property (
        ce && decoder_serial_done |=> s_r.flags_one[DS_BIT])
        else $error("serial transfer end did not set its flag");

    chk_transfer_sets: assert property (
        ce && sleep_exec && direct_transfer_on |=> s_r.flags_two[DT_BIT])
        else $error("sleep with transfer on did not set its flag");

    chk_tg_ovf_sets: assert property (
        ce && timer_g_overflow && overflow_irq_enable |=> s_r.flags_two[TG_BIT])
        else $error("timer G overflow did not set its flag");

    chk_fh_match_sets: assert property (
        ce && fh_match && !s_r.fh_match_prev
        |=> s_r.flags_two[TFH_BIT])
        else $error("timer FH match did not set its flag");

    chk_edge_needs_func: assert property (
        ce && !s_r.pin_func[1] && !s_r.flags_one[1]
        |=> !s_r.flags_one[1])
        else $error("edge flag 1 set while line not configured");

    cov_edge_flag: cover property (
        ce && edge_pulse[1] ##1 s_r.flags_one[1]);
    cov_fh_16bit: cover property (
        ce && timer_f_16bit_mode && set_two[TFH_BIT]);
    cov_clear_flag: cover property (
        ce && wr_flags_two && s_r.flags_two[TC_BIT]
        ##1 !s_r.flags_two[TC_BIT]);
    cov_request_out: cover property (req_two[TG_BIT]);
    cov_set_wins: cover property (ce && wr_flags_one && set_one[DS_BIT]);
endmodule

// ==== verification/iefr_periph_model.sv ====
// behavioural model of the timers, serial, converter and sleep sources
`timescale 1ns/1ps
module iefr_periph_model (
    input wire logic mclk, // system clock
    output logic [7:0] ta_cnt, // timer A counter
    output logic ser_done, // serial transfer end pulse
    output logic sleep_ex, // sleep instruction pulse
    output logic dt_on, // direct transfer control
    output logic cs_flag, // converter busy flag
    output logic tg_ovf, // timer G overflow pulse
    output logic ovf_en, // timer G overflow irq enable
    output logic [7:0] fh_cnt, // timer F high counter
    output logic [7:0] fl_cnt, // timer F low counter
    output logic f16, // timer F cascaded mode
    output logic [7:0] tc_cnt // timer C counter
);
    // idle levels: no counter near a wrap, no compare match
    initial begin
        ta_cnt = 8'h10;
        tc_cnt = 8'h10;
        fh_cnt = 8'h01;
        fl_cnt = 8'h01;
        {ser_done, sleep_ex, dt_on, cs_flag, tg_ovf, ovf_en, f16} = 7'h00;
    end

    // one source event; gate low drops its qualifier
    task automatic fire(input int k, input logic gate);
        @(posedge mclk);
        case (k)
            0: ta_cnt <= 8'hFF;
            1: ser_done <= 1'b1;
            2: begin
                dt_on <= gate;
                sleep_ex <= 1'b1;
            end
            3: cs_flag <= 1'b1;
            4: begin
                ovf_en <= gate;
                tg_ovf <= 1'b1;
            end
            5: begin
                f16 <= 1'b0;
                fh_cnt <= 8'h80;
            end
            6: begin
                f16 <= ~gate;
                fl_cnt <= 8'h80;
            end
            7: tc_cnt <= 8'h00;
            default: begin
                f16 <= 1'b1;
                fh_cnt <= 8'h80;
                fl_cnt <= 8'h80;
            end
        endcase
        @(posedge mclk);
        ser_done <= 1'b0;
        sleep_ex <= 1'b0;
        cs_flag <= 1'b0;
        tg_ovf <= 1'b0;
        ta_cnt <= (k == 0) ? 8'h00 : 8'h10;
        tc_cnt <= (k == 7) ? 8'hFF : 8'h10;
        fh_cnt <= 8'h01;
        fl_cnt <= 8'h01;
        @(posedge mclk);
        ta_cnt <= 8'h10;
        tc_cnt <= 8'h10;
    endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the request flag and enable block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
module tb;
    import iefr_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [4:1] ext_pin = 4'hF;
    logic dec_rdy = 1'b1;
    logic tg_pin = 1'b0;
    logic [7:0] reg_rdata, req_one, req_two, rv;
    logic [7:0] ta_cnt, fh_cnt, fl_cnt, tc_cnt;
    logic ser_done, sleep_ex, dt_on, cs_flag, tg_ovf, ovf_en, f16;
    int error_cnt = 0;
    int comparisons = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    iefr_top DUT (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_edge_pin(ext_pin),
        .decoder_ready(dec_rdy), .timer_a_count(ta_cnt),
        .decoder_serial_done(ser_done), .sleep_exec(sleep_ex),
        .direct_transfer_on(dt_on), .converter_start_flag(cs_flag),
        .timer_g_input_pin(tg_pin), .timer_g_overflow(tg_ovf),
        .overflow_irq_enable(ovf_en), .timer_f_high_counter(fh_cnt),
        .timer_f_high_compare(8'h80), .timer_f_low_counter(fl_cnt),
        .timer_f_low_compare(8'h80), .timer_f_16bit_mode(f16),
        .timer_c_count(tc_cnt), .req_one(req_one), .req_two(req_two)
    );

    iefr_periph_model P (
        .mclk(mclk), .ta_cnt(ta_cnt), .ser_done(ser_done),
        .sleep_ex(sleep_ex), .dt_on(dt_on), .cs_flag(cs_flag),
        .tg_ovf(tg_ovf), .ovf_en(ovf_en), .fh_cnt(fh_cnt),
        .fl_cnt(fl_cnt), .f16(f16), .tc_cnt(tc_cnt)
    );

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // drive the edge lines and let sync and detect settle
    task automatic pins(input logic [4:1] p, input logic r, input logic g);
        @(posedge mclk);
        ext_pin <= p;
        dec_rdy <= r;
        tg_pin <= g;
        repeat (6) @(posedge mclk);
    endtask

    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // reset values of every register, one unmapped place
    task automatic t_reset;
        logic [7:0] ex [7] = '{8'h00, 8'h00, 8'hE0, 8'h20, 8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 7; a++) begin
            rd(8'(a));
            `CHK("rst", ex[a], rv)
        end
        `CHK("req one", 8'h00, req_one)
        `CHK("req two", 8'h00, req_two)
    endtask

    // reserved bits and write-one on clear flags
    task automatic t_reserved;
        wr(ADDR_ENABLE_TWO, 8'hFF);
        rd(ADDR_ENABLE_TWO);
        `CHK("enable two", 8'hFE, rv)
        wr(ADDR_FLAGS_ONE, 8'hFF);
        rd(ADDR_FLAGS_ONE);
        `CHK("flags one", 8'h20, rv)
        wr(ADDR_FLAGS_TWO, 8'hFF);
        rd(ADDR_FLAGS_TWO);
        `CHK("flags two", 8'h20, rv)
        wr(ADDR_FLAGS_TWO, 8'h00);
        rd(ADDR_FLAGS_TWO);
        `CHK("flags two", 8'h00, rv)
        wr(8'h06, 8'hFF);
        rd(8'h06);
        `CHK("unmapped", 8'h00, rv)
    endtask

    // every timer, serial, converter and sleep source sets its own flag, which stays until written 0
    task automatic t_events;
        int eb [9] = '{7, 6, 7, 6, 4, 3, 2, 1, 3};
        int nk [3] = '{2, 4, 6};
        logic [7:0] a, m, fx, got;
        wr(ADDR_ENABLE_ONE, 8'hFF);
        wr(ADDR_ENABLE_TWO, 8'hFF);
        for (int k = 0; k < 9; k++) begin
            a = (k < 2) ? ADDR_FLAGS_ONE : ADDR_FLAGS_TWO;
            fx = (k < 2) ? FLAGS_ONE_FIXED : 8'h00;
            m = 8'h01 << eb[k];
            P.fire(k, 1'b1);
            repeat (20) @(posedge mclk);
            rd(a);
            `CHK("set", m | fx, rv)
            got = (k < 2) ? (req_one & FLAGS_ONE_CLR) : req_two;
            `CHK("req", m, got)
            wr(a, m);
            rd(a);
            `CHK("kept", m | fx, rv)
            wr(a, 8'h00);
            rd(a);
            `CHK("cleared", fx, rv)
        end
        for (int i = 0; i < 3; i++) begin
            P.fire(nk[i], 1'b0);
            rd(ADDR_FLAGS_TWO);
            `CHK("no set", 8'h00, rv)
        end
    endtask

    // each timer enable bit of register two passes only its own request
    task automatic t_gating;
        for (int k = 4; k < 8; k++) begin
            P.fire(k, 1'b1);
        end
        for (int b = 1; b < 5; b++) begin
            wr(ADDR_ENABLE_TWO, 8'h01 << b);
            #1;
            `CHK("gated", 8'h01 << b, req_two)
        end
        wr(ADDR_ENABLE_TWO, 8'h00);
        #1;
        `CHK("gated", 8'h00, req_two)
        wr(ADDR_FLAGS_TWO, 8'h00);
    endtask

    // edge lines: unconfigured, falling, rising, wrong edge
    task automatic t_edges;
        pins(4'h0, 1'b0, 1'b0);
        rd(ADDR_FLAGS_ONE);
        `CHK("unconfigured", 8'h20, rv)
        pins(4'hF, 1'b1, 1'b0);
        wr(ADDR_PIN_FUNC, 8'h1F);
        pins(4'h0, 1'b0, 1'b0);
        rd(ADDR_FLAGS_ONE);
        `CHK("falling", 8'h3F, rv)
        wr(ADDR_FLAGS_ONE, 8'h00);
        wr(ADDR_EDGE_SEL, 8'h1F);
        wr(ADDR_PIN_FUNC, 8'h7F);
        rd(ADDR_EDGE_SEL);
        `CHK("edge sel", 8'hFF, rv)
        pins(4'hF, 1'b1, 1'b1);
        rd(ADDR_FLAGS_ONE);
        `CHK("rising", 8'h3F, rv)
        rd(ADDR_FLAGS_TWO);
        `CHK("tg pin", 8'h10, rv)
        wr(ADDR_FLAGS_ONE, 8'h00);
        wr(ADDR_FLAGS_TWO, 8'h00);
        pins(4'h0, 1'b0, 1'b0);
        rd(ADDR_FLAGS_ONE);
        `CHK("wrong edge", 8'h20, rv)
    endtask

    // event and clearing write land on the same edge
    task automatic t_collide;
        fork
            wr(ADDR_FLAGS_ONE, 8'h00);
            P.fire(1, 1'b1);
        join
        rd(ADDR_FLAGS_ONE);
        `CHK("set wins", 8'h60, rv)
    endtask

    // clock enable low: events and writes are dropped, then resume
    task automatic t_freeze;
        wr(ADDR_FLAGS_ONE, 8'h00);
        @(posedge mclk);
        ce <= 1'b0;
        P.fire(1, 1'b1);
        wr(ADDR_FLAGS_TWO, 8'h20);
        #1;
        `CHK("frozen req", 8'h00, req_one)
        @(posedge mclk);
        ce <= 1'b1;
        rd(ADDR_FLAGS_ONE);
        `CHK("frozen one", 8'h20, rv)
        rd(ADDR_FLAGS_TWO);
        `CHK("frozen two", 8'h00, rv)
        P.fire(1, 1'b1);
        rd(ADDR_FLAGS_ONE);
        `CHK("thawed", 8'h60, rv)
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_reserved;
        t_events;
        t_gating;
        t_edges;
        t_collide;
        t_freeze;
        summarize;
    end

    // hang limit
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        summarize;
    end
endmodule
